// File: ivm_vector_map.sv
/*
 * Interrupt vector map: request flags, enables and priorities behind a
 * classic Wishbone slave, arbitration, and the vector fetch toward the core.
 * Assumes peripheral requests are on clk_i; external pins are asynchronous.
 */
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
// Overview of operation
// R1: Alternate select bit redirects all vector fetches
// R2: Alternate entries sit 0x100 above primary
// R3: Reset fetches nothing; execution starts at zero
// R4: Trap vectors 0-7 from 0x04, step two
// R5: Request n uses vector n+8 address 0x14+2n
// R6: Flag, enable, priority bits placed by index
// R7: External pins map to requests 0,20,29
// R8: Capture events 1,2,5,6,22; timer one 3
// R9: Capture time bases map 7,8,27,28,41
// R10: Serial ports 11,12,65 and 30,31,66
// R11: Sync serial ports 16,17 and 49,50
// R12: Conversion done 13, memory write 15
// R13: Comparator 18, input change notify 19
// R14: Clock 62, voltage detect 72, charge 77
// R15: Buffers 78,79, wakeup 80, logic 96,97
// R16: Software places jump at reset address
// R17: Software fills unused entries with reset handler
// R18: Unused alternate table copies primary handlers
// R19: Entry holds 24-bit handler loaded into counter
// R20: Equal level ties go to lower address
// R21: Latch vector number and new level
// R22: Unassigned requests never assert, read zero
`timescale 1ns/10ps
module ivm_vector_map
	import ivm_pkg::*;
(
	// Clock and synchronous reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Classic Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Asynchronous external interrupt pins.
	input wire logic [2:0] ext_pin_irq_i,
	// Peripheral requests on clk_i, one bit per unit.
	input wire logic [4:0] ccp_event_irq_i,
	input wire logic [4:0] ccp_timebase_irq_i,
	input wire logic timer_one_irq_i,
	input wire logic [1:0] uart_rx_irq_i,
	input wire logic [1:0] uart_tx_irq_i,
	input wire logic [1:0] uart_err_irq_i,
	input wire logic [1:0] sync_serial_xfer_irq_i,
	input wire logic [1:0] sync_serial_coll_irq_i,
	input wire logic adc_done_irq_i,
	input wire logic nonvolatile_memory_irq_i,
	input wire logic comparator_irq_i,
	input wire logic input_change_notify_irq_i,
	input wire logic calendar_clock_irq_i,
	input wire logic voltage_level_detect_irq_i,
	input wire logic charge_time_unit_irq_i,
	input wire logic [1:0] dac_update_irq_i,
	input wire logic low_power_wakeup_irq_i,
	input wire logic [1:0] configurable_logic_cell_irq_i,
	// Trap events for vectors 1 to 4.
	input wire logic [3:0] trap_event_i,
	// Core side.
	input wire logic [3:0] cpu_level_i,
	input wire logic cpu_take_i,
	output logic irq_o,
	output logic prog_rd_o,
	output logic [23:0] prog_addr_o,
	input wire logic prog_ack_i,
	input wire logic [23:0] prog_data_i,
	output logic pc_load_o,
	output logic [23:0] pc_value_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [15:0] ctrl_two, next_ctrl_two; // Control, alternate select.
	logic [NUM_REQ-1:0] flag, next_flag; // Request flags.
	logic [NUM_REQ-1:0] enable, next_enable; // Request enables.
	logic [2:0] prio [0:NUM_REQ-1]; // Request priority fields.
	logic [2:0] next_prio [0:NUM_REQ-1];
	logic [7:0] trap_pend, next_trap_pend; // Pending traps.
	logic [6:0] vec_num, next_vec_num; // Latched vector number.
	logic [3:0] level, next_level; // Latched new level.
	ivm_state_type state, next_state; // Fetch sequencer.
	logic [23:0] next_prog_addr;
	logic [23:0] next_pc_value;
	logic next_irq;
	logic [31:0] next_dat;
	logic next_ack;
	logic [2:0] pin_s1, pin_s2, pin_s3; // Pin synchroniser and history.
	logic [2:0] ext_edge; // Rising pin edge, synchronised.
	logic [NUM_REQ-1:0] src_set; // Hardware set, by request number.
	logic best_valid; // Some vector is eligible.
	logic [6:0] best_vec; // Winning vector number.
	logic [3:0] best_lvl; // Winning level.
	logic [23:0] best_addr; // Table entry of the winner.
	logic wr, rd; // Bus write and read strobes.
	// Flags and enables padded to whole 16-bit registers, so that the top
	// register's unused bits read as zero instead of out-of-range unknowns.
	logic [16*FLAG_REGS-1:0] flag_wr, enable_wr;

	// Merge the selected low byte lanes of a 16-bit register.
	function automatic logic [15:0] lane16(input logic [3:0] sel,
		input logic [15:0] old, input logic [31:0] dat);
		lane16 = old;
		if (sel[0]) lane16[7:0] = dat[7:0];
		if (sel[1]) lane16[15:8] = dat[15:8];
	endfunction

	// ****************************************************************
	// External pin synchroniser
	// ****************************************************************
	// Only the second and third stages feed logic; the first is metastability guard.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			pin_s3 <= 3'h0;
		end else begin
			pin_s1 <= ext_pin_irq_i;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end
	assign ext_edge = pin_s2 & ~pin_s3;

	// ****************************************************************
	// Source routing
	// ****************************************************************
	// Each source lands on its fixed request number; all others stay low.
	always_comb begin
		src_set = '0; // [R22]
		for (int i = 0; i < 3; i++) begin
			src_set[EXT_IRQ[i]] = ext_edge[i]; // [R7]
		end
		for (int i = 0; i < 5; i++) begin
			src_set[CCP_EV_IRQ[i]] = ccp_event_irq_i[i]; // [R8]
			src_set[CCP_TB_IRQ[i]] = ccp_timebase_irq_i[i]; // [R9]
		end
		for (int i = 0; i < 2; i++) begin
			src_set[UART_RX_IRQ[i]] = uart_rx_irq_i[i]; // [R10]
			src_set[UART_TX_IRQ[i]] = uart_tx_irq_i[i]; // [R10]
			src_set[UART_ERR_IRQ[i]] = uart_err_irq_i[i]; // [R10]
			src_set[SSP_XFER_IRQ[i]] = sync_serial_xfer_irq_i[i]; // [R11]
			src_set[SSP_COLL_IRQ[i]] = sync_serial_coll_irq_i[i]; // [R11]
			src_set[DAC_IRQ[i]] = dac_update_irq_i[i]; // [R15]
			src_set[CLC_IRQ[i]] = configurable_logic_cell_irq_i[i]; // [R15]
		end
		src_set[TIMER_ONE_IRQ] = timer_one_irq_i; // [R8]
		src_set[ADC_IRQ] = adc_done_irq_i; // [R12]
		src_set[NVM_IRQ] = nonvolatile_memory_irq_i; // [R12]
		src_set[CMP_IRQ] = comparator_irq_i; // [R13]
		src_set[ICN_IRQ] = input_change_notify_irq_i; // [R13]
		src_set[RTC_IRQ] = calendar_clock_irq_i; // [R14]
		src_set[VOLTAGE_LEVEL_DETECT_IRQ] = voltage_level_detect_irq_i; // [R14]
		src_set[CHARGE_TIME_UNIT_IRQ] = charge_time_unit_irq_i; // [R14]
		src_set[LOW_POWER_WAKEUP_IRQ] = low_power_wakeup_irq_i; // [R15]
	end

	// ****************************************************************
	// Arbitration
	// ****************************************************************
	// Traps beat every user level. Loops run downward so that on equal
	// level the later, lower-numbered candidate wins.
	always_comb begin
		best_valid = 1'b0;
		best_vec = 7'h00;
		best_lvl = 4'h0;
		for (int t = TRAP_COUNT - 1; t >= 0; t--) begin
			if (trap_pend[t]) begin
				best_valid = 1'b1;
				best_vec = 7'(t); // [R4]
				best_lvl = TRAP_LEVEL;
			end
		end
		if (!best_valid) begin
			for (int n = NUM_REQ - 1; n >= 0; n--) begin
				if (flag[n] && enable[n] && prio[n] != 3'h0
					&& {1'b0, prio[n]} > cpu_level_i
					&& (!best_valid || {1'b0, prio[n]} >= best_lvl)) begin
					best_valid = 1'b1; // [R20]
					best_vec = 7'(n) + USER_VEC_BASE; // [R5]
					best_lvl = {1'b0, prio[n]};
				end
			end
		end
	end

	ivm_vec_addr u_vec_addr (
		.vec_num_i(best_vec),
		.alt_i(ctrl_two[ALT_SELECT_BIT]),
		.addr_o(best_addr)
	);

	// ****************************************************************
	// Register file, bus answer and fetch sequencer
	// ****************************************************************
	// Ack is registered, so every access answers one cycle after strobe.
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

	always_comb begin
		next_ctrl_two = ctrl_two;
		flag_wr = (16*FLAG_REGS)'(flag);
		enable_wr = (16*FLAG_REGS)'(enable);
		next_prio = prio;
		next_trap_pend = trap_pend;
		next_vec_num = vec_num;
		next_level = level;
		next_state = state;
		next_prog_addr = prog_addr_o;
		next_pc_value = pc_value_o;
		next_dat = 32'h00000000; // Unmapped reads return zero.
		next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		// Bus writes, low two lanes only.
		if (wr && wb_adr_i == CTRL_TWO_ADDR) begin
			next_ctrl_two = lane16(wb_sel_i, ctrl_two, wb_dat_i); // [R1]
		end
		for (int k = 0; k < FLAG_REGS; k++) begin
			if (wr && wb_adr_i == FLAG_BASE_ADDR + 12'(4 * k)) begin
				flag_wr[16*k +: 16] = lane16(wb_sel_i,
					flag_wr[16*k +: 16], wb_dat_i); // [R6]
			end
			if (wr && wb_adr_i == ENABLE_BASE_ADDR + 12'(4 * k)) begin
				enable_wr[16*k +: 16] = lane16(wb_sel_i,
					enable_wr[16*k +: 16], wb_dat_i); // [R6]
			end
			if (rd && wb_adr_i == FLAG_BASE_ADDR + 12'(4 * k))
				next_dat[15:0] = flag_wr[16*k +: 16];
			if (rd && wb_adr_i == ENABLE_BASE_ADDR + 12'(4 * k))
				next_dat[15:0] = enable_wr[16*k +: 16];
		end
		for (int k = 0; k < PRIO_REGS; k++) begin
			for (int j = 0; j < 4; j++) begin
				if (4 * k + j < NUM_REQ) begin
					if (wr && wb_sel_i[j/2]
						&& wb_adr_i == PRIO_BASE_ADDR + 12'(4 * k)) begin
						next_prio[4*k+j] = wb_dat_i[4*j +: 3]; // [R6]
					end
					if (rd && wb_adr_i == PRIO_BASE_ADDR + 12'(4 * k))
						next_dat[4*j +: 3] = prio[4*k+j];
				end
			end
		end
		if (rd && wb_adr_i == CTRL_TWO_ADDR)
			next_dat[15:0] = ctrl_two;
		if (rd && wb_adr_i == VEC_STATUS_ADDR)
			next_dat[15:0] = {4'h0, level, 1'b0, vec_num}; // [R21]
		// Hardware sets win over software clears in the same cycle.
		next_flag = (NUM_REQ'(flag_wr) | src_set) & IMPL_MASK; // [R22]
		next_enable = NUM_REQ'(enable_wr) & IMPL_MASK; // [R22]
		for (int n = 0; n < NUM_REQ; n++) begin
			if (!IMPL_MASK[n]) next_prio[n] = 3'h0; // [R22]
		end
		// Fetch sequencer: latch winner, read its entry, load the counter.
		case (state)
			ST_IDLE: begin
				if (cpu_take_i && best_valid) begin
					next_vec_num = best_vec; // [R21]
					next_level = best_lvl; // [R21]
					next_prog_addr = best_addr; // [R1]
					next_state = ST_FETCH;
					if (best_vec < 7'(TRAP_COUNT))
						next_trap_pend[best_vec[2:0]] = 1'b0;
				end
			end
			ST_FETCH: begin
				if (prog_ack_i) begin
					next_pc_value = prog_data_i; // [R19]
					next_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// New trap events win over the clear on take.
		next_trap_pend = next_trap_pend
			| ({3'h0, trap_event_i, 1'b0} & TRAP_IMPL); // [R4]
		next_irq = best_valid;
	end

	// Reset clears everything; no vector is fetched and the counter
	// value shown is the reset address.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_two <= REG_RESET;
			flag <= '0;
			enable <= '0;
			for (int n = 0; n < NUM_REQ; n++) prio[n] <= 3'h0;
			trap_pend <= 8'h00;
			vec_num <= 7'h00;
			level <= 4'h0;
			state <= ST_IDLE; // [R3]
			prog_addr_o <= RESET_ADDR;
			pc_value_o <= RESET_ADDR; // [R3]
			irq_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			wb_ack_o <= 1'b0;
		end else begin
			ctrl_two <= next_ctrl_two;
			flag <= next_flag;
			enable <= next_enable;
			prio <= next_prio;
			trap_pend <= next_trap_pend;
			vec_num <= next_vec_num;
			level <= next_level;
			state <= next_state;
			prog_addr_o <= next_prog_addr;
			pc_value_o <= next_pc_value;
			irq_o <= next_irq;
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
		end
	end

	assign prog_rd_o = (state == ST_FETCH);
	assign pc_load_o = (state == ST_LOAD);

	// ****************************************************************
	// Checks
	// ****************************************************************
	alt_fetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_IDLE && cpu_take_i && best_valid
		&& ctrl_two[ALT_SELECT_BIT] |=> prog_addr_o >= 24'h000104) // [R1]
		else $error("alternate select ignored on fetch");
	alt_offset_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_IDLE && cpu_take_i && best_valid |=>
		prog_addr_o == {16'h0000, vec_num, 1'b0} + 24'h000004
		+ ($past(ctrl_two[ALT_SELECT_BIT]) ? 24'h000100 : 24'h0)) // [R2]
		else $error("vector entry address wrong");
	reset_quiet_a: assert property (@(posedge clk_i)
		$past(rst_i) |-> !prog_rd_o && !pc_load_o
		&& pc_value_o == 24'h0) // [R3]
		else $error("fetch activity right after reset");
	pin_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_edge[1] |=> flag[20]) // [R7]
		else $error("pin one edge did not flag request");
	timer_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		timer_one_irq_i |=> flag[3]) // [R8]
		else $error("timer one request not flagged");
	load_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
		prog_rd_o && prog_ack_i |=> pc_load_o
		&& pc_value_o == $past(prog_data_i) ##1 !pc_load_o) // [R19]
		else $error("handler address not loaded once");
	vec_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_IDLE && cpu_take_i && best_valid |=>
		vec_num == $past(best_vec) && level == $past(best_lvl)) // [R21]
		else $error("vector number or level not latched");
	unused_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(flag & ~IMPL_MASK) == '0 && (enable & ~IMPL_MASK) == '0) // [R22]
		else $error("unassigned request bit set");
	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");

endmodule

// File: ivm_pkg.sv
/*
 * Constants and types for the interrupt vector map: table bases, request
 * numbers of each source, register offsets and reset values.
 * Assumes a 32-bit classic Wishbone register bus and 24-bit program space.
 */
package ivm_pkg;

	// ****************************************************************
	// Sizes and table layout
	// ****************************************************************
	localparam int NUM_REQ = 98;
	localparam int FLAG_REGS = 7;
	localparam int PRIO_REGS = 25;
	localparam int TRAP_COUNT = 8;
	localparam logic [6:0] USER_VEC_BASE = 7'h08;
	localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
	localparam logic [23:0] ALT_TABLE_OFFSET = 24'h000100;
	localparam logic [23:0] RESET_ADDR = 24'h000000;
	localparam logic [3:0] TRAP_LEVEL = 4'hf;
	localparam int ALT_SELECT_BIT = 15;
	localparam logic [7:0] TRAP_IMPL = 8'h1e;

	// ****************************************************************
	// Request numbers of the sources
	// ****************************************************************
	localparam int EXT_IRQ [0:2] = '{0, 20, 29};
	localparam int CCP_EV_IRQ [0:4] = '{1, 2, 5, 6, 22};
	localparam int CCP_TB_IRQ [0:4] = '{7, 8, 27, 28, 41};
	localparam int UART_RX_IRQ [0:1] = '{11, 30};
	localparam int UART_TX_IRQ [0:1] = '{12, 31};
	localparam int UART_ERR_IRQ [0:1] = '{65, 66};
	localparam int SSP_XFER_IRQ [0:1] = '{16, 49};
	localparam int SSP_COLL_IRQ [0:1] = '{17, 50};
	localparam int DAC_IRQ [0:1] = '{78, 79};
	localparam int CLC_IRQ [0:1] = '{96, 97};
	localparam int TIMER_ONE_IRQ = 3;
	localparam int ADC_IRQ = 13;
	localparam int NVM_IRQ = 15;
	localparam int CMP_IRQ = 18;
	localparam int ICN_IRQ = 19;
	localparam int RTC_IRQ = 62;
	localparam int VOLTAGE_LEVEL_DETECT_IRQ = 72;
	localparam int CHARGE_TIME_UNIT_IRQ = 77;
	localparam int LOW_POWER_WAKEUP_IRQ = 80;

	// ****************************************************************
	// Register map (byte addresses) and reset values
	// ****************************************************************
	localparam logic [11:0] CTRL_TWO_ADDR = 12'h000;
	localparam logic [11:0] VEC_STATUS_ADDR = 12'h004;
	localparam logic [11:0] FLAG_BASE_ADDR = 12'h040;
	localparam logic [11:0] ENABLE_BASE_ADDR = 12'h080;
	localparam logic [11:0] PRIO_BASE_ADDR = 12'h100;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Sequencer states, Gray coded along idle, fetch, load.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_LOAD = 2'b11
	} ivm_state_type;

	// Mask of request numbers that have a source wired to them.
	function automatic logic [NUM_REQ-1:0] impl_mask();
		logic [NUM_REQ-1:0] m;
		m = '0;
		for (int i = 0; i < 3; i++) m[EXT_IRQ[i]] = 1'b1;
		for (int i = 0; i < 5; i++) begin
			m[CCP_EV_IRQ[i]] = 1'b1;
			m[CCP_TB_IRQ[i]] = 1'b1;
		end
		for (int i = 0; i < 2; i++) begin
			m[UART_RX_IRQ[i]] = 1'b1;
			m[UART_TX_IRQ[i]] = 1'b1;
			m[UART_ERR_IRQ[i]] = 1'b1;
			m[SSP_XFER_IRQ[i]] = 1'b1;
			m[SSP_COLL_IRQ[i]] = 1'b1;
			m[DAC_IRQ[i]] = 1'b1;
			m[CLC_IRQ[i]] = 1'b1;
		end
		m[TIMER_ONE_IRQ] = 1'b1;
		m[ADC_IRQ] = 1'b1;
		m[NVM_IRQ] = 1'b1;
		m[CMP_IRQ] = 1'b1;
		m[ICN_IRQ] = 1'b1;
		m[RTC_IRQ] = 1'b1;
		m[VOLTAGE_LEVEL_DETECT_IRQ] = 1'b1;
		m[CHARGE_TIME_UNIT_IRQ] = 1'b1;
		m[LOW_POWER_WAKEUP_IRQ] = 1'b1;
		return m;
	endfunction

	localparam logic [NUM_REQ-1:0] IMPL_MASK = impl_mask();

endpackage

// File: ivm_vec_addr.sv
/*
 * Table address of a vector number in the primary or alternate table.
 * Assumes the vector number is below 128 and entries are two words apart.
 */
`timescale 1ns/10ps
module ivm_vec_addr
	import ivm_pkg::*;
(
	// Vector selection.
	input wire logic [6:0] vec_num_i,
	input wire logic alt_i,
	// Resulting entry address.
	output logic [23:0] addr_o
);

	// ****************************************************************
	// Address arithmetic
	// ****************************************************************
	logic [23:0] base; // Table base selected by the alternate bit.

	// The alternate table mirrors the primary order, one page higher.
	always_comb begin
		base = alt_i ? PRIMARY_TABLE_BASE + ALT_TABLE_OFFSET
			: PRIMARY_TABLE_BASE; // [R1] [R2]
		addr_o = base + {16'h0000, vec_num_i, 1'b0}; // [R4] [R5]
	end

endmodule

// File: ivm_core_model.sv
/*
 * Behavioural program memory on the core side of the interrupt vector map.
 * It answers vector entry reads after a chosen number of cycles.
 * Assumes one clock and a synchronous, active-high reset.
 */
`timescale 1ns/10ps
module ivm_core_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Entry read from the vector map.
	input wire logic prog_rd_i,
	input wire logic [23:0] prog_addr_i,
	input wire logic [7:0] delay_i,
	// Answer toward the vector map.
	output logic prog_ack_o,
	output logic [23:0] prog_data_o
);

	// ****************************************
	// Table contents and answer timing
	// ****************************************
	logic [7:0] wait_cnt; // Cycles spent on the current read.

	// Every entry, used or not, holds a distinct handler address, the
	// reset entry included. The alternate table is in use here, so its
	// entries deliberately differ from the primary ones.
	function automatic logic [23:0] entry(input logic [23:0] a);
		return a ^ 24'h5a5a00;
	endfunction

	// Answers delay_i + 1 cycles into a read. Off a read the data bus inverts
	// its word on every cycle, so a stale word never holds steady.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_ack_o <= 1'b0;
			prog_data_o <= 24'h000000;
			wait_cnt <= 8'h00;
		end else if (prog_rd_i && !prog_ack_o) begin
			if (wait_cnt >= delay_i) begin
				prog_ack_o <= 1'b1;
				prog_data_o <= entry(prog_addr_i);
				wait_cnt <= 8'h00;
			end else begin
				wait_cnt <= wait_cnt + 8'h01;
			end
		end else begin
			prog_ack_o <= 1'b0;
			prog_data_o <= ~prog_data_o;
		end
	end
endmodule

// File: test_interrupt_vector_map.sv
/*
 * Self-checking bench for the interrupt vector map: register placement,
 * source wiring, vector fetch, traps and reset.
 * Assumes the core model answers entry reads from its own table.
 */
`timescale 1ns/10ps
module test_interrupt_vector_map
	import ivm_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_i;
	logic rst_i;
	logic cyc; // Drives both cycle and strobe.
	logic we;
	logic [11:0] adr;
	logic [31:0] dat;
	logic [127:0] src; // One line per request number.
	logic [3:0] trap;
	logic [3:0] lvl; // Core priority level.
	logic take;
	logic alt; // Table the current fetch should use.
	logic [7:0] dly; // Model answer delay.
	logic [7:0] seed;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_o;
	logic prog_rd_o;
	logic [23:0] prog_addr_o;
	logic prog_ack;
	logic [23:0] prog_data;
	logic pc_load_o;
	logic [23:0] pc_value_o;
	logic [127:0] msk; // Request numbers that have a source.
	int bad_count;
	int cmp_count;
	int impl_n [36] = '{0, 1, 2, 3, 5, 6, 7, 8, 11, 12, 13, 15, 16, 17, 18,
		19, 20, 22, 27, 28, 29, 30, 31, 41, 49, 50, 62, 65, 66, 72, 77, 78,
		79, 80, 96, 97};

	ivm_vector_map ivm_vector_map_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ext_pin_irq_i({src[29], src[20], src[0]}),
		.ccp_event_irq_i({src[22], src[6], src[5], src[2], src[1]}),
		.ccp_timebase_irq_i({src[41], src[28], src[27], src[8], src[7]}),
		.timer_one_irq_i(src[3]), .uart_rx_irq_i({src[30], src[11]}),
		.uart_tx_irq_i({src[31], src[12]}),
		.uart_err_irq_i({src[66], src[65]}),
		.sync_serial_xfer_irq_i({src[49], src[16]}),
		.sync_serial_coll_irq_i({src[50], src[17]}),
		.adc_done_irq_i(src[13]), .nonvolatile_memory_irq_i(src[15]),
		.comparator_irq_i(src[18]), .input_change_notify_irq_i(src[19]),
		.calendar_clock_irq_i(src[62]), .voltage_level_detect_irq_i(src[72]),
		.charge_time_unit_irq_i(src[77]), .dac_update_irq_i({src[79], src[78]}),
		.low_power_wakeup_irq_i(src[80]),
		.configurable_logic_cell_irq_i({src[97], src[96]}),
		.trap_event_i(trap), .cpu_level_i(lvl), .cpu_take_i(take),
		.irq_o(irq_o), .prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr_o),
		.prog_ack_i(prog_ack), .prog_data_i(prog_data),
		.pc_load_o(pc_load_o), .pc_value_o(pc_value_o));

	ivm_core_model ivm_core_model_inst (
		.clk_i(clk_i), .rst_i(rst_i), .prog_rd_i(prog_rd_o),
		.prog_addr_i(prog_addr_o), .delay_i(dly), .prog_ack_o(prog_ack),
		.prog_data_o(prog_data));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Handler word the model keeps at an entry address.
	function automatic logic [23:0] handler(input logic [23:0] a);
		return a ^ 24'h5a5a00;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	// One classic bus cycle; the request stands until ack is sampled.
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	// Takes one vector and checks entry address, handler and status.
	task automatic fetch(input int vec, input logic [3:0] lv);
		logic [23:0] a;
		logic [31:0] q;
		a = 24'h000004 + 24'(2 * vec) + (alt ? 24'h000100 : 24'h000000);
		take <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (prog_rd_o !== 1'b1);
		take <= 1'b0;
		chk(irq_o, 32'h1, "request line");
		chk(prog_addr_o, a, "entry");
		do begin
			@(posedge clk_i);
		end while (pc_load_o !== 1'b1);
		chk(pc_value_o, handler(a), "handler");
		wb(1'b0, VEC_STATUS_ADDR, 32'h0, q);
		chk(q, {20'h0, lv, 1'b0, 7'(vec)}, "status");
	endtask

	// Pulses one source, checks its flag bit, then fetches its vector.
	task automatic src_case(input int n);
		logic [31:0] q;
		logic [31:0] e;
		logic [3:0] lv;
		seed = lfsr(seed);
		lv = (seed[2:0] == 3'h0) ? 4'h1 : {1'b0, seed[2:0]};
		alt = seed[7];
		dly <= {6'h00, seed[5:4]};
		src[n] <= 1'b1;
		repeat (2) @(posedge clk_i);
		src[n] <= 1'b0;
		repeat (6) @(posedge clk_i);
		e = 32'h1 << (n % 16);
		wb(1'b0, FLAG_BASE_ADDR + 12'(4 * (n / 16)), 32'h0, q);
		chk(q, e, "flag");
		wb(1'b1, CTRL_TWO_ADDR, {16'h0, alt, 15'h0}, q);
		wb(1'b1, PRIO_BASE_ADDR + 12'(4 * (n / 4)), 32'(lv) << (4 * (n % 4)), q);
		wb(1'b1, ENABLE_BASE_ADDR + 12'(4 * (n / 16)), e, q);
		// A level equal to the core's own must not be taken.
		lvl <= lv;
		take <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk({prog_rd_o, irq_o}, 32'h0, "refused at equal level");
		lvl <= lv - 4'h1;
		fetch(n + 8, lv);
		wb(1'b1, FLAG_BASE_ADDR + 12'(4 * (n / 16)), 32'h0, q);
		wb(1'b1, ENABLE_BASE_ADDR + 12'(4 * (n / 16)), 32'h0, q);
		wb(1'b1, PRIO_BASE_ADDR + 12'(4 * (n / 4)), 32'h0, q);
	endtask

	task automatic check_reset();
		logic [31:0] q;
		chk({irq_o, prog_rd_o, pc_load_o}, 32'h0, "core side");
		chk(pc_value_o, RESET_ADDR, "program counter");
		wb(1'b1, 12'hffc, 32'hffff, q);
		wb(1'b0, 12'hffc, 32'h0, q);
		chk(q, 32'h0, "unmapped");
		wb(1'b0, CTRL_TWO_ADDR, 32'h0, q);
		chk(q, 32'h0, "control");
		wb(1'b0, VEC_STATUS_ADDR, 32'h0, q);
		chk({q[31:1], irq_o}, 32'h0, "status");
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and main sequence
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// The run needs a few thousand cycles; this leaves a wide margin.
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		test_done();
	end

	initial begin
		logic [31:0] q;
		logic [31:0] e;
		rst_i = 1'b1;
		{cyc, we, adr, dat, src, trap, lvl, take, alt, dly} = '0;
		seed = 8'h5e;
		bad_count = 0;
		cmp_count = 0;
		msk = '0;
		foreach (impl_n[i]) msk[impl_n[i]] = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check_reset();
		// Writable bits exist only where a source is wired.
		for (int k = 0; k < 7; k++) begin
			e = {16'h0, msk[16 * k +: 16]};
			wb(1'b1, ENABLE_BASE_ADDR + 12'(4 * k), 32'hffff, q);
			wb(1'b0, ENABLE_BASE_ADDR + 12'(4 * k), 32'h0, q);
			chk(q, e, "enable bits");
			wb(1'b1, FLAG_BASE_ADDR + 12'(4 * k), 32'hffff, q);
			wb(1'b0, FLAG_BASE_ADDR + 12'(4 * k), 32'h0, q);
			chk(q, e, "flag bits");
			wb(1'b1, FLAG_BASE_ADDR + 12'(4 * k), 32'h0, q);
			wb(1'b1, ENABLE_BASE_ADDR + 12'(4 * k), 32'h0, q);
		end
		for (int k = 0; k < 25; k++) begin
			e = 32'h0;
			for (int j = 0; j < 4; j++) if (msk[4 * k + j]) e |= 32'h7 << (4 * j);
			wb(1'b1, PRIO_BASE_ADDR + 12'(4 * k), 32'h7777, q);
			wb(1'b0, PRIO_BASE_ADDR + 12'(4 * k), 32'h0, q);
			chk(q, e, "priority fields");
			wb(1'b1, PRIO_BASE_ADDR + 12'(4 * k), 32'h0, q);
		end
		foreach (impl_n[i]) src_case(impl_n[i]);
		// Two sources at one level: the lower table address goes first.
		alt = 1'b0;
		lvl <= 4'h0;
		wb(1'b1, CTRL_TWO_ADDR, 32'h0, q);
		wb(1'b1, PRIO_BASE_ADDR, 32'h4000, q);
		wb(1'b1, PRIO_BASE_ADDR + 12'h03c, 32'h0400, q);
		wb(1'b1, ENABLE_BASE_ADDR, 32'h0008, q);
		wb(1'b1, ENABLE_BASE_ADDR + 12'h00c, 32'h4000, q);
		src[3] <= 1'b1;
		src[62] <= 1'b1;
		@(posedge clk_i);
		src[3] <= 1'b0;
		src[62] <= 1'b0;
		repeat (2) @(posedge clk_i);
		fetch(11, 4'h4);
		wb(1'b1, FLAG_BASE_ADDR, 32'h0, q);
		fetch(70, 4'h4);
		wb(1'b1, FLAG_BASE_ADDR + 12'h00c, 32'h0, q);
		// All four traps, from the alternate table, despite a full mask.
		alt = 1'b1;
		wb(1'b1, CTRL_TWO_ADDR, 32'h8000, q);
		lvl <= 4'hf;
		trap <= 4'hf;
		@(posedge clk_i);
		trap <= 4'h0;
		@(posedge clk_i);
		for (int i = 1; i < 5; i++) fetch(i, TRAP_LEVEL);
		// Reset in the middle of a slow entry read.
		dly <= 8'h1e;
		trap <= 4'h1;
		@(posedge clk_i);
		trap <= 4'h0;
		take <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b1;
		take <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check_reset();
		test_done();
	end
endmodule
